// ---- src/aar_params.svh ----
// Register offsets, field codes, resource tables and timing constants of the audio adapter
`ifndef AAR_PARAMS_SVH
`define AAR_PARAMS_SVH

// ------------------------------------------------------------
// Register byte offsets
// ------------------------------------------------------------
`define AAR_ADDR_W 8
`define AAR_OFS_CTRL 8'h00
`define AAR_OFS_CFG 8'h04
`define AAR_OFS_SAMPLE 8'h08
`define AAR_OFS_STATUS 8'h0c
`define AAR_OFS_INT_STAT 8'h10
`define AAR_OFS_INT_EN 8'h14
`define AAR_OFS_INT_CLR 8'h18

// ------------------------------------------------------------
// Field widths and reset values
// ------------------------------------------------------------
`define AAR_CTRL_W 10
`define AAR_CFG_W 10
`define AAR_CTRL_RST 10'h000
`define AAR_CFG_RST 10'h1ff
`define AAR_SEL_NONE 3'h7
`define AAR_CH_CASCADE 3'h4
`define AAR_EV_W 2
`define AAR_EV_REQ 0
`define AAR_EV_UNDER 1

// ------------------------------------------------------------
// Base address tables, first and second personality
// ------------------------------------------------------------
`define AAR_BASE_A0 16'h0220
`define AAR_BASE_A1 16'h0240
`define AAR_BASE_A2 16'h0260
`define AAR_BASE_A3 16'h0280
`define AAR_BASE_A4 16'h02a0
`define AAR_BASE_A5 16'h02c0
`define AAR_BASE_A6 16'h02e0
`define AAR_BASE_B0 16'h0388
`define AAR_BASE_B1 16'h0530
`define AAR_BASE_B2 16'h0604
`define AAR_BASE_B3 16'h0e80
`define AAR_BASE_B4 16'h0f40
`define AAR_BASE_B5 16'h0320
`define AAR_BASE_B6 16'h0340

// ------------------------------------------------------------
// Interrupt line tables, first and second personality
// ------------------------------------------------------------
`define AAR_IRQ_A {4'hc, 4'hb, 4'ha, 4'h9, 4'h7, 4'h5, 4'h3}
`define AAR_IRQ_B {4'hf, 4'h5, 4'h3, 4'hb, 4'ha, 4'h9, 4'h7}

// ------------------------------------------------------------
// Timing
// ------------------------------------------------------------
`define AAR_CLK_HZ 100000000
`define AAR_RATE_LO_HZ 22050
`define AAR_RATE_HI_HZ 44100
`define AAR_CYC_LO (`AAR_CLK_HZ / `AAR_RATE_LO_HZ)
`define AAR_CYC_HI (`AAR_CLK_HZ / `AAR_RATE_HI_HZ)
`define AAR_CNT_W 13
`define AAR_DEC_SPAN 16

`endif

// ---- src/aar_pkg.sv ----
// Types shared by the audio adapter resource logic
`include "aar_params.svh"

package aar_pkg;

	typedef enum logic {PERS_A, PERS_B} aar_pers_t;

	typedef enum logic [1:0] {FMT_MONO8, FMT_MONO16, FMT_STEREO16} aar_fmt_t;

	typedef struct packed {
		logic [3:0] vol;
		logic tone_en;
		logic rate_hi;
		aar_fmt_t fmt;
		aar_pers_t pers;
		logic enable;
	} aar_ctrl_t;

	typedef struct packed {
		logic dma_en;
		logic [2:0] dma_ch;
		logic [2:0] irq_sel;
		logic [2:0] base_sel;
	} aar_cfg_t;

	typedef struct packed {
		aar_ctrl_t ctrl;
		aar_cfg_t cfg;
		logic [`AAR_EV_W-1:0] stat;
		logic [`AAR_EV_W-1:0] ien;
		logic [31:0] prdata;
		logic slverr;
		logic [15:0] hold_l;
		logic [15:0] hold_r;
		logic full;
		logic phase;
		logic [`AAR_CNT_W-1:0] cnt;
		logic [15:0] pcm_l;
		logic [15:0] pcm_r;
		logic pvalid;
		logic tone;
	} aar_state_t;

endpackage : aar_pkg

// ---- src/aar_resource_decode.sv ----
// Audio adapter: APB configuration, ISA resource decode and routing, playback timing
//
// Functional notes
// - Plays mono audio, 8-bit samples, at 22 kHz or faster; no recording.
// - First personality offers base addresses 220h and 240h.
// - Second personality offers 388h, 530h, 604h, 0E80h and 0F40h.
// - First personality routes interrupt to IRQ3, 5, 7, 9 or 10.
// - Second personality routes interrupt to IRQ7, 9, 10 or 11.
// - DMA request and acknowledge selectable among three or more 8/16-bit channels.
// - Second personality may use any 8-bit DMA channel 0 through 3.
// - Disable state claims no address, drives no interrupt or DMA request.
// - Address, interrupt and DMA selections are reprogrammable by software.
// - Seven or more base addresses, first personality including its two standard ones.
// - Base decode has its own off setting claiming no address.
// - Interrupt routable to seven or more lines, plus a no-line setting.
// - Supports 16-bit stereo at 44 kHz with software volume.
//
// Design decisions made here: the placing of the registers and the APB interface to the registers.
`timescale 1ns/100ps
`default_nettype none
`include "aar_params.svh"

module aar_resource_decode
	import aar_pkg::*;
#(
	parameter int CYC_LO = `AAR_CYC_LO,
	parameter int CYC_HI = `AAR_CYC_HI,
	parameter int DEC_SPAN = `AAR_DEC_SPAN
) (
	input wire logic pclk, // Bus clock
	input wire logic presetn, // Async reset, active low
	input wire logic psel, // APB select
	input wire logic penable, // APB access phase
	input wire logic pwrite, // APB direction
	input wire logic [`AAR_ADDR_W-1:0] paddr, // APB byte address
	input wire logic [31:0] pwdata, // APB write data
	output logic [31:0] prdata, // APB read data
	output logic pready, // APB ready
	output logic pslverr, // APB error on unmapped address
	output logic irq, // Level interrupt
	input wire logic [15:0] isa_addr, // ISA I/O address
	input wire logic isa_iow, // ISA I/O write strobe
	input wire logic [15:0] isa_wdata, // ISA write data
	output logic isa_claim, // Address falls in our window
	output logic [15:0] isa_irq, // Routed interrupt lines
	output logic [7:0] isa_drq, // DMA requests
	input wire logic [7:0] isa_dack, // DMA acknowledges
	output logic [15:0] pcm_left, // Left sample
	output logic [15:0] pcm_right, // Right sample
	output logic pcm_valid, // New sample pulse
	input wire logic tone_in, // Legacy timer tone
	output logic tone_out // Tone toward speaker
);

	// ------------------------------------------------------------
	// Elaboration checks
	// ------------------------------------------------------------
	// The sample counter is 13 bits wide
	if (CYC_LO < 1 || CYC_HI < 1 || CYC_LO > 8191 || CYC_HI > 8191 || DEC_SPAN < 1
		|| DEC_SPAN > 256) begin : g_bad_param
		$error("aar_resource_decode: parameter out of range");
	end

	// ------------------------------------------------------------
	// Resource tables
	// ------------------------------------------------------------
	// Base address for a selection; code 7 means decode off
	function automatic logic [15:0] base_of(input aar_pers_t pers, input logic [2:0] sel);
		logic [15:0] b;
		b = 16'h0000;
		if (pers == PERS_A) begin
			case (sel)
				3'h0: b = `AAR_BASE_A0;
				3'h1: b = `AAR_BASE_A1;
				3'h2: b = `AAR_BASE_A2;
				3'h3: b = `AAR_BASE_A3;
				3'h4: b = `AAR_BASE_A4;
				3'h5: b = `AAR_BASE_A5;
				3'h6: b = `AAR_BASE_A6;
				default: b = 16'h0000;
			endcase
		end else begin
			case (sel)
				3'h0: b = `AAR_BASE_B0;
				3'h1: b = `AAR_BASE_B1;
				3'h2: b = `AAR_BASE_B2;
				3'h3: b = `AAR_BASE_B3;
				3'h4: b = `AAR_BASE_B4;
				3'h5: b = `AAR_BASE_B5;
				3'h6: b = `AAR_BASE_B6;
				default: b = 16'h0000;
			endcase
		end
		return b;
	endfunction : base_of

	// Line number for an interrupt selection
	function automatic logic [3:0] line_of(input aar_pers_t pers, input logic [2:0] sel);
		logic [27:0] tab;
		tab = (pers == PERS_A) ? `AAR_IRQ_A : `AAR_IRQ_B;
		return tab[sel*4 +: 4];
	endfunction : line_of

	// ------------------------------------------------------------
	// State and decode terms
	// ------------------------------------------------------------
	aar_state_t s_q;
	aar_state_t s_d;
	logic [15:0] base;
	logic [16:0] win_end;
	logic apb_wr;
	logic apb_smp;
	logic dma_ok;
	logic dma_hit;
	logic isa_load;
	logic [15:0] isa_pcm;
	logic tick;
	logic [`AAR_CNT_W-1:0] reload;
	logic [`AAR_EV_W-1:0] ev;
	logic [`AAR_EV_W-1:0] clr;

	// Window of the selected base; zero wait states on APB
	assign base = base_of(s_q.ctrl.pers, s_q.cfg.base_sel);
	assign win_end = {1'b0, base} + 17'(DEC_SPAN);
	assign pready = 1'b1;
	assign apb_wr = psel && penable && pwrite;
	assign apb_smp = apb_wr && paddr == `AAR_OFS_SAMPLE;

	// Off state and decode-off code both silence the decoder
	assign isa_claim = s_q.ctrl.enable && s_q.cfg.base_sel != `AAR_SEL_NONE
		&& isa_addr >= base && {1'b0, isa_addr} < win_end;

	// Channel 4 is the cascade and never requested
	assign dma_ok = s_q.ctrl.enable && s_q.cfg.dma_en && s_q.cfg.dma_ch != `AAR_CH_CASCADE;
	assign dma_hit = dma_ok && isa_dack[s_q.cfg.dma_ch] && isa_iow;
	assign isa_load = (dma_hit || (isa_claim && isa_iow && isa_addr == base)) && !apb_smp;

	// Narrow samples are unsigned; widen to signed 16-bit
	assign isa_pcm = (s_q.ctrl.fmt == FMT_MONO8) ? {isa_wdata[7:0] ^ 8'h80, 8'h00} : isa_wdata;

	// Sample period from the selected rate
	assign reload = s_q.ctrl.rate_hi ? `AAR_CNT_W'(CYC_HI - 1) : `AAR_CNT_W'(CYC_LO - 1);
	assign tick = s_q.ctrl.enable && s_q.cnt == '0;
	assign clr = (apb_wr && paddr == `AAR_OFS_INT_CLR) ? pwdata[`AAR_EV_W-1:0] : '0;

	// ------------------------------------------------------------
	// Routed requests
	// ------------------------------------------------------------
	// One line and one channel at most; nothing while off
	always_comb begin
		isa_irq = '0;
		isa_drq = '0;
		if (irq && s_q.ctrl.enable && s_q.cfg.irq_sel != `AAR_SEL_NONE) begin
			isa_irq[line_of(s_q.ctrl.pers, s_q.cfg.irq_sel)] = 1'b1;
		end
		if (dma_ok && !s_q.full) begin
			isa_drq[s_q.cfg.dma_ch] = 1'b1;
		end
	end

	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------
	always_comb begin
		s_d = s_q;
		ev = '0;
		s_d.pvalid = 1'b0;
		s_d.tone = tone_in && s_q.ctrl.tone_en && s_q.ctrl.enable;
		// Read data is latched in the setup cycle so it comes from a flop
		if (psel && !penable) begin
			s_d.prdata = '0;
			s_d.slverr = 1'b0;
			case (paddr)
				`AAR_OFS_CTRL: s_d.prdata[`AAR_CTRL_W-1:0] = s_q.ctrl;
				`AAR_OFS_CFG: s_d.prdata[`AAR_CFG_W-1:0] = s_q.cfg;
				`AAR_OFS_SAMPLE: s_d.prdata = {s_q.hold_r, s_q.hold_l};
				`AAR_OFS_STATUS: s_d.prdata[3:0] = {isa_claim, |isa_drq, s_q.phase, s_q.full};
				`AAR_OFS_INT_STAT: s_d.prdata[`AAR_EV_W-1:0] = s_q.stat;
				`AAR_OFS_INT_EN: s_d.prdata[`AAR_EV_W-1:0] = s_q.ien;
				`AAR_OFS_INT_CLR: s_d.prdata = '0;
				default: s_d.slverr = 1'b1;
			endcase
		end
		// Selections move only at the completing edge of their write
		if (apb_wr) begin
			case (paddr)
				`AAR_OFS_CTRL: s_d.ctrl = aar_ctrl_t'(pwdata[`AAR_CTRL_W-1:0]);
				`AAR_OFS_CFG: s_d.cfg = aar_cfg_t'(pwdata[`AAR_CFG_W-1:0]);
				`AAR_OFS_INT_EN: s_d.ien = pwdata[`AAR_EV_W-1:0];
				default: s_d.ien = s_q.ien;
			endcase
		end
		// Sample clock: consume the holding pair or flag an underrun
		if (s_q.ctrl.enable) begin
			s_d.cnt = tick ? reload : s_q.cnt - `AAR_CNT_W'(1);
		end
		if (tick) begin
			if (s_q.full) begin
				s_d.pcm_l = 16'($signed(s_q.hold_l) >>> s_q.ctrl.vol);
				s_d.pcm_r = 16'($signed(s_q.hold_r) >>> s_q.ctrl.vol);
				s_d.pvalid = 1'b1;
				s_d.full = 1'b0;
				ev[`AAR_EV_REQ] = 1'b1;
			end else begin
				ev[`AAR_EV_UNDER] = 1'b1;
			end
		end
		// A full holding pair refuses further writes
		if (apb_smp && !s_q.full) begin
			s_d.hold_l = pwdata[15:0];
			s_d.hold_r = (s_q.ctrl.fmt == FMT_STEREO16) ? pwdata[31:16] : pwdata[15:0];
			s_d.full = 1'b1;
			s_d.phase = 1'b0;
		end else if (isa_load && !s_q.full) begin
			if (s_q.ctrl.fmt == FMT_STEREO16 && !s_q.phase) begin
				s_d.hold_l = isa_pcm;
				s_d.phase = 1'b1;
			end else if (s_q.ctrl.fmt == FMT_STEREO16) begin
				s_d.hold_r = isa_pcm;
				s_d.phase = 1'b0;
				s_d.full = 1'b1;
			end else begin
				s_d.hold_l = isa_pcm;
				s_d.hold_r = isa_pcm;
				s_d.full = 1'b1;
			end
		end
		// Set wins over a clear in the same cycle
		s_d.stat = (s_q.stat & ~clr) | ev;
	end

	// ------------------------------------------------------------
	// State register
	// ------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_q <= '0;
			s_q.ctrl <= aar_ctrl_t'(`AAR_CTRL_RST);
			s_q.cfg <= aar_cfg_t'(`AAR_CFG_RST);
		end else begin
			s_q <= s_d;
		end
	end

	// Outputs straight from flops, except irq, which gates stat with ien
	assign prdata = s_q.prdata;
	assign pslverr = s_q.slverr;
	assign irq = |(s_q.stat & s_q.ien);
	assign pcm_left = s_q.pcm_l;
	assign pcm_right = s_q.pcm_r;
	assign pcm_valid = s_q.pvalid;
	assign tone_out = s_q.tone;

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	sequence seq_cfg_write;
		psel && penable && pwrite && paddr == `AAR_OFS_CFG;
	endsequence

	sequence seq_mono8_load;
		isa_load && !s_q.full && s_q.ctrl.fmt == FMT_MONO8;
	endsequence

	a_off_quiet: assert property (!s_q.ctrl.enable |-> !isa_claim && isa_irq == '0
		&& isa_drq == '0) else $error("disabled adapter still drives resources");
	a_base_first: assert property (s_q.ctrl.enable && s_q.ctrl.pers == PERS_A
		&& s_q.cfg.base_sel == 3'h1 && isa_addr == 16'h0240 |-> isa_claim)
		else $error("first personality second base not decoded");
	a_base_second: assert property (s_q.ctrl.enable && s_q.ctrl.pers == PERS_B
		&& s_q.cfg.base_sel == 3'h2 && isa_addr == 16'h0604 |-> isa_claim
		&& isa_addr + 16'(DEC_SPAN) != 16'h0604) else $error("second personality base missed");
	a_base_off: assert property (s_q.cfg.base_sel == `AAR_SEL_NONE |-> !isa_claim)
		else $error("decode off still claims");
	a_irq_first: assert property (irq && s_q.ctrl.enable && s_q.ctrl.pers == PERS_A
		&& s_q.cfg.irq_sel == 3'h4 |-> isa_irq == 16'h0400) else $error("IRQ10 route wrong");
	a_irq_second: assert property (irq && s_q.ctrl.enable && s_q.ctrl.pers == PERS_B
		&& s_q.cfg.irq_sel == 3'h3 |-> isa_irq == 16'h0800) else $error("IRQ11 route wrong");
	a_irq_none: assert property (s_q.cfg.irq_sel == `AAR_SEL_NONE |-> isa_irq == '0)
		else $error("no-line setting drives a line");
	a_dma_chan: assert property (s_q.ctrl.enable && s_q.ctrl.pers == PERS_B && s_q.cfg.dma_en
		&& s_q.cfg.dma_ch == 3'h3 && !s_q.full |-> isa_drq == 8'h08)
		else $error("DMA channel 3 not requested");
	a_dma_single: assert property ($onehot0(isa_drq) && !isa_drq[4])
		else $error("more than one DMA request");
	a_cfg_apply: assert property (seq_cfg_write |=> s_q.cfg == $past(pwdata[`AAR_CFG_W-1:0])
		&& $stable(s_q.ctrl)) else $error("configuration write not applied");
	a_cfg_hold: assert property (!(psel && penable && pwrite) |=> $stable(s_q.cfg))
		else $error("selection changed without a write");
	a_mono8_conv: assert property (seq_mono8_load |=> s_q.full
		&& s_q.hold_l == {$past(isa_wdata[7:0]) ^ 8'h80, 8'h00} && s_q.hold_l == s_q.hold_r)
		else $error("8-bit sample not widened");
	a_stereo_pair: assert property (isa_load && !s_q.full && s_q.ctrl.fmt == FMT_STEREO16
		&& !s_q.phase |=> !s_q.full && s_q.phase) else $error("stereo left word completed pair");
	a_pcm_spacing: assert property (pcm_valid |=> !pcm_valid [*8])
		else $error("samples closer than the sample period");
	a_tone_pass: assert property (s_q.ctrl.enable && s_q.ctrl.tone_en |=>
		tone_out == $past(tone_in)) else $error("tone not passed through");

endmodule : aar_resource_decode

`default_nettype wire

// ---- verification/aar_isa_host.sv ----
// Behavioural model of the expansion bus host and DMA controller
`timescale 1ns/100ps
`default_nettype none

module aar_isa_host (
	input wire logic pclk, // Bus clock
	input wire logic presetn, // Reset, active low
	input wire logic [15:0] cmd_addr, // Address the host puts out
	input wire logic cmd_wr, // One-cycle I/O write request
	input wire logic [15:0] cmd_data, // Data for I/O and DMA writes
	input wire logic dma_on, // Answer DMA requests
	input wire logic [3:0] dma_wait, // Cycles before acknowledging
	input wire logic [7:0] drq, // Requests from the adapter
	output logic [15:0] isa_addr, // Address bus
	output logic isa_iow, // Write strobe
	output logic [15:0] isa_wdata, // Data bus
	output logic [7:0] isa_dack // Acknowledges
);
	logic [15:0] last_q;
	logic [3:0] cnt_q;

	// Released data bus shows the inverse so a stale value never passes
	assign isa_addr = cmd_addr;
	assign isa_wdata = isa_iow ? last_q : ~last_q;

	// One transfer at a time; acknowledge only the requesting channel
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			isa_iow <= 1'b0;
			isa_dack <= 8'h00;
			cnt_q <= 4'h0;
			last_q <= 16'h0000;
		end else begin
			isa_iow <= 1'b0;
			isa_dack <= 8'h00;
			if (cmd_wr) begin
				isa_iow <= 1'b1;
				last_q <= cmd_data;
			end else if (dma_on && drq != 8'h00 && !isa_iow) begin
				if (cnt_q == dma_wait) begin
					isa_iow <= 1'b1;
					isa_dack <= drq;
					last_q <= cmd_data;
					cnt_q <= 4'h0;
				end else begin
					cnt_q <= cnt_q + 4'h1;
				end
			end
		end
	end
endmodule : aar_isa_host

`default_nettype wire

// ---- verification/aar_resource_decode_test.sv ----
// Self-checking bench of the audio adapter resource block
`timescale 1ns/100ps
`default_nettype none
`include "aar_params.svh"

module aar_resource_decode_test;
	localparam int CLO = 20;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, tone_in = 0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic pready, pslverr, irq, isa_iow, isa_claim, pcm_valid, tone_out, rerr;
	logic [15:0] isa_addr, isa_wdata, isa_irq, pcm_left, pcm_right, base;
	logic [7:0] isa_drq, isa_dack;
	logic [15:0] cmd_addr = 16'h0, cmd_data = 16'h0;
	logic cmd_wr = 0, dma_on = 0;
	logic [3:0] dma_wait = 4'h3;
	logic [15:0] tab [14] = '{`AAR_BASE_A0, `AAR_BASE_A1, `AAR_BASE_A2, `AAR_BASE_A3,
		`AAR_BASE_A4, `AAR_BASE_A5, `AAR_BASE_A6, `AAR_BASE_B0, `AAR_BASE_B1,
		`AAR_BASE_B2, `AAR_BASE_B3, `AAR_BASE_B4, `AAR_BASE_B5, `AAR_BASE_B6};
	logic [27:0] irqt [2] = '{`AAR_IRQ_A, `AAR_IRQ_B};
	int n_mismatch = 0, checks = 0, cyc = 0, i, p, k;

	// Clock
	always #5 pclk = ~pclk;

	aar_resource_decode #(.CYC_LO(CLO), .CYC_HI(10), .DEC_SPAN(16)) uut (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .irq(irq), .isa_addr(isa_addr),
		.isa_iow(isa_iow), .isa_wdata(isa_wdata), .isa_claim(isa_claim),
		.isa_irq(isa_irq), .isa_drq(isa_drq), .isa_dack(isa_dack),
		.pcm_left(pcm_left), .pcm_right(pcm_right), .pcm_valid(pcm_valid),
		.tone_in(tone_in), .tone_out(tone_out));

	aar_isa_host host (
		.pclk(pclk), .presetn(presetn), .cmd_addr(cmd_addr), .cmd_wr(cmd_wr),
		.cmd_data(cmd_data), .dma_on(dma_on), .dma_wait(dma_wait), .drq(isa_drq),
		.isa_addr(isa_addr), .isa_iow(isa_iow), .isa_wdata(isa_wdata),
		.isa_dack(isa_dack));

	// ------------------------------------------------------------
	// Tasks
	// ------------------------------------------------------------
	task chk(input string n, input logic [31:0] e, input logic [31:0] g);
		checks++;
		if (g !== e) begin
			n_mismatch++;
			$display("BAD %s exp %h got %h", n, e, g);
		end
	endtask : chk

	// One APB transfer; extra idle edge so psel is never driven twice in a step
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		rd = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask : apb

	task wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask : wr

	task rdc(input string n, input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk(n, e, rd);
	endtask : rdc

	// One host I/O write; the host strobes at the first edge, the design takes it at the second
	task io_wr(input logic [15:0] a, input logic [15:0] d);
		cmd_addr <= a;
		cmd_data <= d;
		cmd_wr <= 1'b1;
		@(posedge pclk);
		cmd_wr <= 1'b0;
		@(posedge pclk);
	endtask : io_wr

	task probe(input logic [15:0] a, input logic e);
		cmd_addr <= a;
		repeat (2) @(posedge pclk);
		chk("claim", e, isa_claim);
	endtask : probe

	// Bounded waits on the adapter's own signals
	task wait_pcm;
		k = 0;
		while (pcm_valid !== 1'b1 && k < 3 * CLO) begin
			@(posedge pclk);
			k++;
		end
		chk("pcm_valid", 1, pcm_valid);
	endtask : wait_pcm

	task dma_fill(input logic [15:0] d, input logic [3:0] w);
		cmd_data <= d;
		dma_wait <= w;
		dma_on <= 1'b1;
		@(posedge pclk);
		k = 0;
		while (isa_drq !== 8'h00 && k < 40) begin
			@(posedge pclk);
			k++;
		end
		dma_on <= 1'b0;
		chk("drq_drop", 0, isa_drq);
	endtask : dma_fill

	task summarize;
		$display("comparisons %0d mismatches %0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : summarize

	// Hang guard, well above the several hundred cycles the tests need
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 40000) begin
			n_mismatch++;
			$display("BAD timeout exp done got hang");
			summarize();
		end
	end

	// ------------------------------------------------------------
	// Tests
	// ------------------------------------------------------------
	initial begin
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		rdc("ctrl", `AAR_OFS_CTRL, 32'h0);
		rdc("cfg", `AAR_OFS_CFG, 32'h1ff);
		probe(`AAR_BASE_A0, 0);
		apb(1'b0, 8'h1c, 32'h0);
		chk("slverr", 1, rerr);
		chk("pready", 1, pready);
		$display("test reset done");
		for (p = 0; p < 2; p++) begin
			for (i = 0; i < 7; i++) begin
				base = tab[p * 7 + i];
				wr(`AAR_OFS_CTRL, 1 + 2 * p);
				wr(`AAR_OFS_CFG, 32'h1f8 | i);
				probe(base, 1);
				probe(base + 16'd15, 1);
				probe(base + 16'd16, 0);
				probe(base - 16'd1, 0);
				wr(`AAR_OFS_CFG, 32'h1ff);
				probe(base, 0);
			end
		end
		wr(`AAR_OFS_CFG, 32'h1f9);
		probe(`AAR_BASE_B0, 0);
		probe(`AAR_BASE_B1, 1);
		$display("test decode done");
		// Underrun events feed the interrupt path
		wr(`AAR_OFS_INT_EN, 32'h2);
		wr(`AAR_OFS_CTRL, 32'h1);
		repeat (CLO + 4) @(posedge pclk);
		rdc("int_stat", `AAR_OFS_INT_STAT, 32'h2);
		chk("irq", 1, irq);
		for (p = 0; p < 2; p++) begin
			for (i = 0; i < 7; i++) begin
				wr(`AAR_OFS_CTRL, 1 + 2 * p);
				wr(`AAR_OFS_CFG, 32'h1c7 | (i << 3));
				chk("isa_irq", 32'h1 << irqt[p][4 * i +: 4], isa_irq);
			end
		end
		wr(`AAR_OFS_CFG, 32'h1ff);
		chk("isa_irq", 0, isa_irq);
		wr(`AAR_OFS_CFG, 32'h1c7);
		wr(`AAR_OFS_CTRL, 32'h0);
		chk("isa_irq", 0, isa_irq);
		wr(`AAR_OFS_INT_EN, 32'h0);
		chk("irq", 0, irq);
		wr(`AAR_OFS_INT_CLR, 32'h3);
		rdc("int_stat", `AAR_OFS_INT_STAT, 32'h0);
		$display("test interrupt done");
		// DMA channel routing in the second personality, then playback paths
		wr(`AAR_OFS_CTRL, 32'h3);
		for (i = 0; i < 8; i++) begin
			wr(`AAR_OFS_CFG, 32'h23f | (i << 6));
			chk("drq", (i == 4) ? 32'h0 : (32'h1 << i), isa_drq);
		end
		wr(`AAR_OFS_CTRL, 32'h0);
		chk("drq", 0, isa_drq);
		wr(`AAR_OFS_CTRL, 32'h1);
		wr(`AAR_OFS_CFG, 32'h27f);
		dma_fill(16'h00c3, 4'h3);
		apb(1'b0, `AAR_OFS_STATUS, 32'h0);
		chk("full", 1, rd[0]);
		wait_pcm();
		chk("pcm_left", 16'h4300, pcm_left);
		chk("pcm_right", 16'h4300, pcm_right);
		wr(`AAR_OFS_CTRL, 32'h085);
		dma_fill(16'h8000, 4'h0);
		wait_pcm();
		chk("pcm_left", 16'he000, pcm_left);
		wr(`AAR_OFS_CTRL, 32'h009);
		wr(`AAR_OFS_SAMPLE, 32'h1234_5678);
		wait_pcm();
		chk("pcm_left", 16'h5678, pcm_left);
		chk("pcm_right", 16'h1234, pcm_right);
		// Host acknowledges twice: left word, then right word completes the pair
		dma_fill(16'h7ff0, 4'h0);
		wait_pcm();
		chk("pcm_left", 16'h7ff0, pcm_left);
		chk("pcm_right", 16'h7ff0, pcm_right);
		// Data port at offset 0 of the decoded window
		wr(`AAR_OFS_CTRL, 32'h005);
		wr(`AAR_OFS_CFG, 32'h1f8);
		io_wr(`AAR_BASE_A0, 16'h1357);
		wait_pcm();
		chk("pcm_left", 16'h1357, pcm_left);
		chk("pcm_right", 16'h1357, pcm_right);
		rdc("int_stat", `AAR_OFS_INT_STAT, 32'h3);
		$display("test playback done");
		wr(`AAR_OFS_CTRL, 32'h021);
		tone_in <= 1'b1;
		repeat (2) @(posedge pclk);
		chk("tone", 1, tone_out);
		tone_in <= 1'b0;
		repeat (2) @(posedge pclk);
		chk("tone", 0, tone_out);
		wr(`AAR_OFS_CTRL, 32'h001);
		tone_in <= 1'b1;
		repeat (2) @(posedge pclk);
		chk("tone", 0, tone_out);
		$display("test tone done");
		summarize();
	end
endmodule : aar_resource_decode_test

`default_nettype wire
